// *** mag_defines.svh ***
/*
  Register indices, field positions, reset values and timing counts of the
  melody and alarm tone generator. Assumes inclusion by bare name.
*/
`ifndef MAG_DEFINES_SVH
`define MAG_DEFINES_SVH

// Register indices; byte address is four times the index
`define MAG_IDX_ALARM 16'h1330
`define MAG_IDX_CTRL 16'h1331
`define MAG_IDX_DIVLO 16'h1332
`define MAG_IDX_DIVHI 16'h1333
`define MAG_IDX_IRQEN 16'h1334

// Control and divisor high register fields
`define MAG_CTRL_FC_HI 7
`define MAG_CTRL_FC_LO 6
`define MAG_CTRL_INV 5
`define MAG_CTRL_SEL 0
`define MAG_DIVHI_RUN 7

// Reset values
`define MAG_RST_BYTE 8'h00
`define MAG_RST_IRQEN 5'h00

// Counter control codes
`define MAG_FC_HOLD 2'h0
`define MAG_FC_RUN 2'h1
`define MAG_FC_CLEAR 2'h2
`define MAG_FC_CLRRUN 2'h3

// Low-speed clock and derived rates
`define MAG_LS_HZ 32768
`define MAG_MOD_HZ 4096
`define MAG_MOD_BIT 2
`define MAG_BURST_US 31250
`define MAG_BURST_TICKS ((`MAG_BURST_US * `MAG_LS_HZ) / 1000000)

// AXI responses
`define MAG_RESP_OKAY 2'h0
`define MAG_RESP_SLVERR 2'h2

`endif

// *** mag_pkg.sv ***
/*
  Types shared by the tone generator modules. Assumes nothing else.
*/
package mag_pkg;
  typedef enum logic {FC_STOPPED, FC_RUNNING} mag_fc_e;
  typedef logic [7:0] mag_byte_t;
  typedef logic [4:0] mag_irq_t;
  typedef logic [11:0] mag_div_t;
endpackage

// *** mag_melody_div.sv ***
/*
  Melody divider: square wave of period 2*(N+2) low-speed ticks.
  Assumes lsTick is a one-cycle pulse per low-speed clock rising edge.
*/
module mag_melody_div (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic lsTick,
  input wire logic melRun,
  input wire mag_pkg::mag_div_t divisor,
  output logic melWave
);
  import mag_pkg::*;

  logic [12:0] halfCnt_q;
  logic [12:0] halfEnd;

  assign halfEnd = {1'b0, divisor} + 13'h0001;

  always_ff @(posedge clk) begin
    if (sys_rst || !melRun) begin
      halfCnt_q <= 13'h0000;
      melWave <= 1'b0;
    end else if (lsTick) begin
      if (halfCnt_q >= halfEnd) begin
        halfCnt_q <= 13'h0000;
        melWave <= ~melWave;
      end else begin
        halfCnt_q <= halfCnt_q + 13'h0001;
      end
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  // Checked after each tick so a divisor lowered mid-period is not flagged
  AST_MEL_HALF: assert property (melRun && lsTick |=> halfCnt_q <= $past(halfEnd))
    else $error("Melody half period exceeded");
  AST_MEL_TOGGLE: assert property (melRun && lsTick && halfCnt_q == halfEnd |=> melWave != $past(melWave))
    else $error("Melody did not toggle at divisor plus two");
  AST_MEL_STOP: assert property (!melRun |=> !melWave && halfCnt_q == 13'h0000)
    else $error("Melody not cleared when stopped");
endmodule

// *** mag_tone_top.sv ***
/*
  Melody and alarm tone generator with an AXI4-Lite register slave.
  Assumes lsClk is an asynchronous 32.768 kHz pin, far slower than clk,
  and that tonePin drives an external loudspeaker.
*/
`include "mag_defines.svh"

module mag_tone_top (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic lsClk,
  input wire logic [15:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [15:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic tonePin,
  output mag_pkg::mag_irq_t periodicIrqReq
);
  import mag_pkg::*;

  localparam logic [2:0] SEL_ALARM = 3'h0;
  localparam logic [2:0] SEL_CTRL = 3'h1;
  localparam logic [2:0] SEL_DIVLO = 3'h2;
  localparam logic [2:0] SEL_DIVHI = 3'h3;
  localparam logic [2:0] SEL_IRQEN = 3'h4;
  localparam logic [2:0] SEL_NONE = 3'h7;

  // Byte address to register select; misaligned or unknown gives none
  function automatic logic [2:0] regSelect(input logic [15:0] addr);
    logic [15:0] idx;
    idx = {2'b00, addr[15:2]};
    if (addr[1:0] != 2'b00) begin
      regSelect = SEL_NONE;
    end else if (idx == `MAG_IDX_ALARM) begin
      regSelect = SEL_ALARM;
    end else if (idx == `MAG_IDX_CTRL) begin
      regSelect = SEL_CTRL;
    end else if (idx == `MAG_IDX_DIVLO) begin
      regSelect = SEL_DIVLO;
    end else if (idx == `MAG_IDX_DIVHI) begin
      regSelect = SEL_DIVHI;
    end else if (idx == `MAG_IDX_IRQEN) begin
      regSelect = SEL_IRQEN;
    end else begin
      regSelect = SEL_NONE;
    end
  endfunction

  // Burst gate of each one-hot pattern; out-of-list values give silence
  function automatic logic patternGate(input mag_byte_t sel, input logic [14:0] cnt);
    case (sel)
      8'h01: patternGate = 1'b1;
      8'h02: patternGate = (cnt[11:10] == 2'b00);
      8'h04: patternGate = !cnt[14];
      8'h08: patternGate = !cnt[13];
      8'h10: patternGate = !cnt[12];
      8'h20: patternGate = (cnt[14:12] == 3'b000);
      8'h40: patternGate = (cnt[14:13] == 2'b00) && !cnt[10];
      8'h80: patternGate = !cnt[9];
      default: patternGate = 1'b0;
    endcase
  endfunction

  // Low-speed clock synchroniser and edge detect
  logic lsMeta_q;
  logic lsSync_q;
  logic lsPrev_q;
  logic lsTick;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      lsMeta_q <= 1'b0;
      lsSync_q <= 1'b0;
      lsPrev_q <= 1'b0;
    end else begin
      lsMeta_q <= lsClk;
      lsSync_q <= lsMeta_q;
      lsPrev_q <= lsSync_q;
    end
  end

  assign lsTick = lsSync_q && !lsPrev_q;

  // AXI write channel
  logic awHeld_q;
  logic wHeld_q;
  logic [15:0] awAddr_q;
  logic [7:0] wByte_q;
  logic wLane0_q;
  logic bValid_q;
  logic [1:0] bResp_q;
  logic doWrite;
  logic [2:0] wrSel;

  assign s_axi_awready = !awHeld_q;
  assign s_axi_wready = !wHeld_q;
  assign s_axi_bvalid = bValid_q;
  assign s_axi_bresp = bResp_q;
  assign doWrite = awHeld_q && wHeld_q && !bValid_q;
  assign wrSel = regSelect(awAddr_q);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      awHeld_q <= 1'b0;
      awAddr_q <= 16'h0000;
    end else if (s_axi_awvalid && !awHeld_q) begin
      awHeld_q <= 1'b1;
      awAddr_q <= s_axi_awaddr;
    end else if (doWrite) begin
      awHeld_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wHeld_q <= 1'b0;
      wByte_q <= `MAG_RST_BYTE;
      wLane0_q <= 1'b0;
    end else if (s_axi_wvalid && !wHeld_q) begin
      wHeld_q <= 1'b1;
      wByte_q <= s_axi_wdata[7:0];
      wLane0_q <= s_axi_wstrb[0];
    end else if (doWrite) begin
      wHeld_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bValid_q <= 1'b0;
      bResp_q <= `MAG_RESP_OKAY;
    end else if (doWrite) begin
      bValid_q <= 1'b1;
      bResp_q <= (wrSel == SEL_NONE) ? `MAG_RESP_SLVERR : `MAG_RESP_OKAY;
    end else if (s_axi_bready) begin
      bValid_q <= 1'b0;
    end
  end

  // Register strobes; only byte lane 0 carries data
  logic wrAlarm;
  logic wrCtrl;
  logic wrDivLo;
  logic wrDivHi;
  logic wrIrqEn;
  logic [1:0] fcCode;

  assign wrAlarm = doWrite && wLane0_q && (wrSel == SEL_ALARM);
  assign wrCtrl = doWrite && wLane0_q && (wrSel == SEL_CTRL);
  assign wrDivLo = doWrite && wLane0_q && (wrSel == SEL_DIVLO);
  assign wrDivHi = doWrite && wLane0_q && (wrSel == SEL_DIVHI);
  assign wrIrqEn = doWrite && wLane0_q && (wrSel == SEL_IRQEN);
  assign fcCode = wByte_q[`MAG_CTRL_FC_HI:`MAG_CTRL_FC_LO];

  mag_byte_t alarmSel_q;
  logic invert_q;
  logic outSel_q;
  mag_fc_e fcState_q;
  mag_byte_t divLow_q;
  logic [3:0] divHigh_q;
  logic melRun_q;
  mag_irq_t irqEn_q;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      alarmSel_q <= `MAG_RST_BYTE;
    end else if (wrAlarm) begin
      alarmSel_q <= wByte_q;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      invert_q <= 1'b0;
      outSel_q <= 1'b0;
    end else if (wrCtrl) begin
      invert_q <= wByte_q[`MAG_CTRL_INV];
      outSel_q <= wByte_q[`MAG_CTRL_SEL];
    end
  end

  // Code 00 never stops a running counter; only 10 halts it
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fcState_q <= FC_STOPPED;
    end else if (wrCtrl) begin
      case (fcCode)
        `MAG_FC_RUN: fcState_q <= FC_RUNNING;
        `MAG_FC_CLRRUN: fcState_q <= FC_RUNNING;
        `MAG_FC_CLEAR: fcState_q <= FC_STOPPED;
        default: fcState_q <= fcState_q;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      divLow_q <= `MAG_RST_BYTE;
      divHigh_q <= 4'h0;
      melRun_q <= 1'b0;
    end else begin
      if (wrDivLo) begin
        divLow_q <= wByte_q;
      end
      if (wrDivHi) begin
        divHigh_q <= wByte_q[3:0];
        melRun_q <= wByte_q[`MAG_DIVHI_RUN];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irqEn_q <= `MAG_RST_IRQEN;
    end else if (wrIrqEn) begin
      irqEn_q <= wByte_q[4:0];
    end
  end

  // Free-run counter
  logic [14:0] freeCnt_q;
  logic cntStep;

  assign cntStep = lsTick && (fcState_q == FC_RUNNING);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      freeCnt_q <= 15'h0000;
    end else if (wrCtrl && fcCode[1]) begin
      freeCnt_q <= 15'h0000;
    end else if (cntStep) begin
      freeCnt_q <= freeCnt_q + 15'h0001;
    end
  end

  // Periodic events fire as the low counter bits wrap
  mag_irq_t wrapHit;
  mag_irq_t irqReq_q;

  assign wrapHit[0] = (freeCnt_q == 15'h7FFF);
  assign wrapHit[1] = (freeCnt_q[13:0] == 14'h3FFF);
  assign wrapHit[2] = (freeCnt_q[8:0] == 9'h1FF);
  assign wrapHit[3] = (freeCnt_q[5:0] == 6'h3F);
  assign wrapHit[4] = (freeCnt_q[1:0] == 2'h3);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irqReq_q <= `MAG_RST_IRQEN;
    end else begin
      irqReq_q <= (cntStep && !(wrCtrl && fcCode[1])) ? (wrapHit & irqEn_q) : 5'h00;
    end
  end

  assign periodicIrqReq = irqReq_q;

  // Waveforms and output pin
  logic melWave;
  logic alarmWave;

  mag_melody_div melodyDiv (
    .clk(clk),
    .sys_rst(sys_rst),
    .lsTick(lsTick),
    .melRun(melRun_q),
    .divisor({divHigh_q, divLow_q}),
    .melWave(melWave)
  );

  // Square carrier from counter bit, gated by the burst pattern
  assign alarmWave = patternGate(alarmSel_q, freeCnt_q) && freeCnt_q[`MAG_MOD_BIT];

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tonePin <= 1'b0;
    end else if (outSel_q) begin
      tonePin <= melWave;
    end else begin
      tonePin <= alarmWave ^ invert_q;
    end
  end

  // AXI read channel
  logic rValid_q;
  logic [7:0] rByte_q;
  logic [1:0] rResp_q;
  logic arTake;
  logic [2:0] rdSel;
  logic [7:0] rdMux;

  assign s_axi_arready = !rValid_q;
  assign arTake = s_axi_arvalid && !rValid_q;
  assign rdSel = regSelect(s_axi_araddr);
  assign s_axi_rvalid = rValid_q;
  assign s_axi_rresp = rResp_q;
  assign s_axi_rdata = {24'h000000, rByte_q};

  always_comb begin
    if (rdSel == SEL_ALARM) begin
      rdMux = alarmSel_q;
    end else if (rdSel == SEL_CTRL) begin
      rdMux = {1'b0, fcState_q == FC_RUNNING, invert_q, 4'h0, outSel_q};
    end else if (rdSel == SEL_DIVLO) begin
      rdMux = divLow_q;
    end else if (rdSel == SEL_DIVHI) begin
      rdMux = {melRun_q, 3'b000, divHigh_q};
    end else if (rdSel == SEL_IRQEN) begin
      rdMux = {3'b000, irqEn_q};
    end else begin
      rdMux = 8'h00;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rValid_q <= 1'b0;
      rByte_q <= `MAG_RST_BYTE;
      rResp_q <= `MAG_RESP_OKAY;
    end else if (arTake) begin
      rValid_q <= 1'b1;
      rByte_q <= rdMux;
      rResp_q <= (rdSel == SEL_NONE) ? `MAG_RESP_SLVERR : `MAG_RESP_OKAY;
    end else if (s_axi_rready) begin
      rValid_q <= 1'b0;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  AST_SEL_MELODY: assert property (outSel_q ##1 outSel_q |-> tonePin == $past(melWave))
    else $error("Melody not routed to pin");
  AST_SEL_ALARM: assert property (!outSel_q |=> tonePin == ($past(alarmWave) ^ $past(invert_q)))
    else $error("Alarm not routed to pin");
  AST_DIV_HIGH: assert property (wrDivHi |=> divHigh_q == $past(wByte_q[3:0]) && divLow_q == $past(divLow_q))
    else $error("Divisor high nibble not stored");
  AST_MOD_CARRIER: assert property (!outSel_q && !invert_q && alarmSel_q == 8'h01 |=> tonePin == $past(freeCnt_q[2]))
    else $error("Alarm carrier not at counter bit two");
  AST_ZERO_PATTERN: assert property (!outSel_q && alarmSel_q == 8'h00 |=> tonePin == $past(invert_q))
    else $error("Zero pattern not silent");
  AST_INVERT: assert property (!outSel_q && invert_q && alarmSel_q == 8'h01 && freeCnt_q[2] |=> !tonePin)
    else $error("Alarm not inverted");
  AST_CLEAR: assert property (wrCtrl && fcCode == `MAG_FC_CLEAR |=> freeCnt_q == 15'h0000 && fcState_q == FC_STOPPED)
    else $error("Counter not cleared by code 10");
  AST_FC_READ: assert property (arTake && rdSel == SEL_CTRL |=> !s_axi_rdata[7])
    else $error("Upper control bit read as one");
  AST_KEEP_RUN: assert property (wrCtrl && fcCode == `MAG_FC_HOLD && fcState_q == FC_RUNNING |=> fcState_q == FC_RUNNING)
    else $error("Control write stopped running counter");
  AST_BURST_GAP: assert property (!outSel_q && !invert_q && alarmSel_q == 8'h02 && freeCnt_q[11:10] != 2'b00 |=> !tonePin)
    else $error("Second pattern sounded outside burst");
  AST_IRQ_1HZ: assert property (irqReq_q[0] |-> $past(freeCnt_q) == 15'h7FFF && $past(irqEn_q[0]))
    else $error("One hertz event at wrong count");
  AST_IRQ_GATED: assert property ((irqReq_q & ~$past(irqEn_q)) == 5'h00)
    else $error("Disabled periodic event raised");
  AST_MEL_IDLE: assert property (!melRun_q ##1 !melRun_q |-> !melWave)
    else $error("Melody running while stopped");

  COV_MELODY: cover property (outSel_q && melRun_q && $rose(tonePin));
  COV_BURST: cover property (alarmSel_q == 8'h02 && !outSel_q && $rose(tonePin));
  COV_IRQ_FAST: cover property (irqReq_q[4]);
  COV_BAD_READ: cover property (s_axi_rvalid && s_axi_rresp == `MAG_RESP_SLVERR);
endmodule

// *** mag_speaker_model.sv ***
/*
  Loudspeaker on the tone pin: measures each half period in low-speed ticks.
  Assumes clk far faster than lsClk and tonePin driven by the design.
*/
module mag_speaker_model (
  input wire logic clk,
  input wire logic lsClk,
  input wire logic tonePin,
  output int halfTicks,
  output int toggles
);
  timeunit 1ns;
  timeprecision 100ps;
  logic lsD;
  logic toneD;
  int cnt;
  initial begin
    lsD = 1'b0;
    toneD = 1'b0;
    cnt = 0;
    halfTicks = 0;
    toggles = 0;
  end
  // Pure listener; counts ticks between edges so tone rate is checked in ticks
  always @(posedge clk) begin
    lsD <= lsClk;
    toneD <= tonePin;
    if (tonePin !== toneD) begin
      halfTicks <= cnt;
      cnt <= int'(lsClk && !lsD);
      toggles <= toggles + 1;
    end else if (lsClk && !lsD) begin
      cnt <= cnt + 1;
    end
  end
endmodule

// *** tb_top.sv ***
/*
  Self-checking bench of the tone generator: AXI4-Lite master, register model.
  Assumes the low-speed pin may run fast, since it is only sampled by clk.
*/
`include "mag_defines.svh"
`define CHK(nm, ex, got) begin samplesChecked++; if ((got) !== (ex)) begin badCount++; \
  $display("mismatch %s expected %0h seen %0h", nm, ex, got); end end
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 0, sys_rst = 1, lsClk = 0;
  logic [15:0] awaddr = 0, araddr = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = 0;
  logic awready, wready, bvalid, arready, rvalid, tonePin;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  mag_pkg::mag_irq_t irq;
  int halfTicks, toggles, badCount = 0, samplesChecked = 0, cycles = 0;
  logic [7:0] mdl [5];
  logic run = 0;
  always #2 clk = ~clk;
  // Low-speed pin kept fast to keep the run short
  always #24 lsClk = ~lsClk;
  mag_tone_top u_mag_tone_top (.clk(clk), .sys_rst(sys_rst), .lsClk(lsClk), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .tonePin(tonePin), .periodicIrqReq(irq));
  mag_speaker_model u_mag_speaker_model (.clk(clk), .lsClk(lsClk), .tonePin(tonePin),
    .halfTicks(halfTicks), .toggles(toggles));
  task automatic finalReport();
    $display("checks %0d mismatches %0d", samplesChecked, badCount);
    if (badCount == 0 && samplesChecked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      badCount++;
      finalReport();
    end
  end
  task automatic axiWr(input logic [15:0] a, input logic [7:0] d, output logic [1:0] r);
    logic ah, wh, bh;
    @(posedge clk);
    awaddr <= a; awvalid <= 1; wdata <= {24'h000000, d}; wvalid <= 1; bready <= 1;
    forever begin
      @(negedge clk);
      ah = awvalid & awready; wh = wvalid & wready; bh = bvalid; r = bresp;
      @(posedge clk);
      if (ah) awvalid <= 0;
      if (wh) wvalid <= 0;
      if (bh) begin
        bready <= 0;
        break;
      end
    end
  endtask
  task automatic axiRd(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ah, rh;
    @(posedge clk);
    araddr <= a; arvalid <= 1; rready <= 1;
    forever begin
      @(negedge clk);
      ah = arvalid & arready; rh = rvalid; d = rdata; r = rresp;
      @(posedge clk);
      if (ah) arvalid <= 0;
      if (rh) begin
        rready <= 0;
        break;
      end
    end
  endtask
  function automatic logic [15:0] addrOf(int i);
    return 16'((`MAG_IDX_ALARM + i) * 4);
  endfunction
  task automatic regWr(int i, logic [7:0] d);
    logic [1:0] r;
    axiWr(addrOf(i), d, r);
    `CHK("bresp", `MAG_RESP_OKAY, r)
    case (i)
      1: begin
        if (d[7:6] == 2'h2) run = 0;
        else if (d[6]) run = 1;
        mdl[1] = {1'b0, run, d[5], 4'h0, d[0]};
      end
      3: mdl[3] = {d[7], 3'h0, d[3:0]};
      4: mdl[4] = {3'h0, d[4:0]};
      default: mdl[i] = d;
    endcase
  endtask
  task automatic regChk(int i);
    logic [31:0] d;
    logic [1:0] r;
    axiRd(addrOf(i), d, r);
    `CHK("rdata", {24'h000000, mdl[i]}, d)
    `CHK("rresp", `MAG_RESP_OKAY, r)
  endtask
  task automatic toneChk(int half);
    int t;
    t = toggles;
    wait (toggles >= t + 4);
    `CHK("halfTicks", half, halfTicks)
  endtask
  task automatic irqCount(int bitSel, int ticks, output int n);
    n = 0;
    repeat (ticks * 12) begin
      @(negedge clk);
      if (irq[bitSel] === 1'b1) n++;
    end
  endtask
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    int n, nDiv;
    foreach (mdl[i]) mdl[i] = 8'h00;
    void'($urandom(48290));
    repeat (4) @(posedge clk);
    sys_rst <= 0;
    for (int i = 0; i < 5; i++) regChk(i);
    axiRd(addrOf(5), d, r);
    `CHK("rresp", `MAG_RESP_SLVERR, r)
    `CHK("rdata", 32'h00000000, d)
    regWr(0, 8'(1 << ($urandom % 8)));
    regWr(3, 8'($urandom % 16));
    regWr(4, 8'h1F);
    regWr(1, 8'hC1);
    regChk(1);
    regWr(1, 8'h21);
    regChk(1);
    regWr(1, 8'h80);
    for (int i = 0; i < 5; i++) regChk(i);
    $display("test registers done");
    nDiv = 1 + $urandom % 6;
    regWr(1, 8'h01);
    regWr(2, 8'(nDiv));
    regWr(3, 8'h80);
    toneChk(nDiv + 2);
    regWr(3, 8'h00);
    repeat (3) @(posedge lsClk);
    `CHK("toneStop", 1'b0, tonePin)
    $display("test melody done");
    regWr(1, 8'h80);
    regWr(1, 8'h40);
    regWr(0, 8'h01);
    toneChk(4);
    regWr(1, 8'h80);
    regWr(1, 8'h40);
    regWr(0, 8'h02);
    toneChk(4);
    regWr(0, 8'h00);
    repeat (3) @(posedge lsClk);
    `CHK("alarmZero", 1'b0, tonePin)
    regWr(1, 8'h20);
    repeat (3) @(posedge lsClk);
    `CHK("alarmInv", 1'b1, tonePin)
    $display("test alarm done");
    regWr(4, 8'h10);
    irqCount(4, 40, n);
    `CHK("irq8192", 1'b1, n >= 9 && n <= 11)
    regWr(4, 8'h00);
    irqCount(4, 40, n);
    `CHK("irqMasked", 0, n)
    regWr(4, 8'h08);
    irqCount(3, 128, n);
    `CHK("irq512", 2, n)
    $display("test interrupts done");
    finalReport();
  end
endmodule
